// ==== bench/i2csw_master.sv ====
// i2c master model on the upstream bus: drives scl, pulls sda low or releases it
// assumes sda is resolved outside with a pull-up; each half bit is several clk_sys cycles
`timescale 1ns/100ps
`default_nettype none
module i2csw_master (
    input wire logic clk_sys,
    input wire logic sda,
    output var logic scl,
    output var logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic half(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // data moves only while scl is low, sampled mid high
    task automatic put_bit(input logic b, output logic seen);
        sda_low <= ~b;
        half(5);
        scl <= 1'b1;
        half(5);
        seen = sda;
        half(5);
        scl <= 1'b0;
        half(5);
    endtask
    task automatic start_c;
        sda_low <= 1'b0;
        half(5);
        scl <= 1'b1;
        half(5);
        sda_low <= 1'b1;
        half(5);
        scl <= 1'b0;
        half(5);
    endtask
    task automatic stop_c;
        sda_low <= 1'b1;
        half(5);
        scl <= 1'b1;
        half(5);
        sda_low <= 1'b0;
        half(10);
    endtask
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) put_bit(d[i], s);
        put_bit(1'b1, s);
        ack = ~s;
    endtask
    task automatic recv_byte(input logic ack_n, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, s);
            d[i] = s;
        end
        put_bit(ack_n, s);
    endtask
endmodule
`default_nettype wire

// ==== bench/i2csw_monitor.sv ====
// checker for the four-channel i2c bus switch, watching the top module ports only
// assumes clk_sys at 10 MHz and upstream lines idling high
`timescale 1ns/100ps
`default_nettype none
module i2csw_monitor
    import i2csw_pkg::*;
#(
    parameter logic [1:0] VARIANT = VAR_SWITCH2
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic scl,
    input wire logic sda_in,
    input wire logic sda_oe_n,
    input wire logic chan0_irq_in_n,
    input wire logic chan1_irq_in_n,
    input wire logic chan2_irq_in_n,
    input wire logic chan3_irq_in_n,
    input wire logic irq_oe_n,
    input wire logic [i2csw_pkg::NCHAN-1:0] chan_connected,
    input wire logic [i2csw_pkg::NCHAN-1:0] chan_data_oe_n,
    input wire logic [i2csw_pkg::NCHAN-1:0] chan_clock_oe_n,
    input wire logic [i2csw_pkg::SEL_W-1:0] channel_select
);
    logic sda_p_q;
    logic [5:0] stop_q;
    logic [5:0] lo_q;
    logic [5:0] hi_q;
    logic any_low;
    assign any_low = !(chan0_irq_in_n && chan1_irq_in_n && chan2_irq_in_n && chan3_irq_in_n);
    // counters saturate so long idle spans never wrap into a false pass
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sda_p_q <= 1'b1;
            // reset clears the selection legally, so it counts like a stop
            stop_q <= 6'h00;
            lo_q <= 6'h00;
            hi_q <= 6'h00;
        end else begin
            sda_p_q <= sda_in;
            stop_q <= (scl && sda_in && !sda_p_q) ? 6'h00 : (stop_q == 6'h3F) ? stop_q : stop_q + 6'h01;
            lo_q <= !any_low ? 6'h00 : (lo_q == 6'h3F) ? lo_q : lo_q + 6'h01;
            hi_q <= any_low ? 6'h00 : (hi_q == 6'h3F) ? hi_q : hi_q + 6'h01;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    reset_clear_a: assert property ($rose(resetn) |-> channel_select == '0 && chan_connected == '0)
        else $error("selection not clear after reset");
    irq_assert_a: assert property (lo_q >= 6'h28 |-> !irq_oe_n)
        else $error("interrupt output late to assert");
    irq_release_a: assert property (hi_q >= 6'h14 |-> irq_oe_n)
        else $error("interrupt output late to release");
    // look back past the filter delay: a long enough pulse may already be over when the output moves
    low_reject_a: assert property ($fell(irq_oe_n) |-> $past(lo_q, 5) >= 6'h09)
        else $error("short low pulse passed");
    high_reject_a: assert property ($rose(irq_oe_n) |-> $past(hi_q, 5) >= 6'h04)
        else $error("short high pulse passed");
    stop_apply_a: assert property ($changed(channel_select) |-> stop_q <= 6'h10)
        else $error("selection changed away from stop");
    sel_map_a: assert property ($changed(channel_select) && VARIANT != VAR_MUX |-> ##[0:2] chan_connected == channel_select)
        else $error("connections differ from selection");
    mux_single_a: assert property (VARIANT != VAR_MUX || $onehot0(chan_connected))
        else $error("mux connects several channels");
    start_high_a: assert property ((chan_connected & ~$past(chan_connected) & ~(chan_data_oe_n & chan_clock_oe_n)) == '0)
        else $error("new channel not high");
    idle_release_a: assert property ((~chan_connected & ~(chan_data_oe_n & chan_clock_oe_n)) == '0)
        else $error("unconnected channel pulled");
    sda_stable_a: assert property ($changed(sda_oe_n) |-> !scl)
        else $error("sda moved while scl high");
    cover property ($changed(channel_select));
    cover property ($fell(irq_oe_n));
    cover property ($fell(sda_oe_n));
endmodule
bind i2csw_top i2csw_monitor #(.VARIANT(VARIANT)) u_i2csw_monitor (.clk_sys, .resetn, .scl, .sda_in, .sda_oe_n,
    .chan0_irq_in_n, .chan1_irq_in_n, .chan2_irq_in_n, .chan3_irq_in_n, .irq_oe_n, .chan_connected,
    .chan_data_oe_n, .chan_clock_oe_n, .channel_select);
`default_nettype wire

// ==== bench/i2csw_top_bench.sv ====
// self-checking bench for the i2c bus switch: a two-pin switch and a multiplexer share one bus
// assumes the link sampler clock is the upstream scl wire itself
`timescale 1ns/100ps
`default_nettype none
module i2csw_top_bench;
    import i2csw_pkg::*;
    localparam logic [6:0] ADDR_SELF = {ADDR_FIX5, 2'b10};
    localparam logic [6:0] ADDR_MUX = {ADDR_FIX4, 3'b110};
    logic clk_sys = 1'b0;
    logic resetn = 1'b1;
    logic pin0 = 1'b0;
    logic pin1 = 1'b1;
    logic [3:0] irq_n = 4'hF;
    logic scl, sda_low, sda, sda_out, sda_oe_n, irq_out, irq_oe_n, ok;
    logic [3:0] conn, data_oe_n, clock_oe_n, sel;
    logic sda_oe_n_m;
    logic [3:0] conn_m, sel_m;
    int fail_count = 0;
    int compares = 0;
    // the multiplexer sits on the same bus at an address of its own
    assign sda = ~sda_low & (sda_oe_n | sda_out) & sda_oe_n_m;
    always #50 clk_sys = ~clk_sys;
    i2csw_master u_i2csw_master (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_low(sda_low));
    i2csw_top u_i2csw_top (.clk_sys(clk_sys), .resetn(resetn), .scl_link_clk(scl), .scl(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_pin_bit_zero(pin0), .addr_pin_bit_one(pin1),
        .addr_pin_bit_two(1'b0), .chan0_irq_in_n(irq_n[0]), .chan1_irq_in_n(irq_n[1]),
        .chan2_irq_in_n(irq_n[2]), .chan3_irq_in_n(irq_n[3]), .irq_out(irq_out), .irq_oe_n(irq_oe_n),
        .chan_connected(conn), .chan_data_oe_n(data_oe_n), .chan_clock_oe_n(clock_oe_n), .channel_select(sel));
    i2csw_top #(.VARIANT(VAR_MUX)) u_i2csw_top_mux (.clk_sys(clk_sys), .resetn(resetn), .scl_link_clk(scl),
        .scl(scl), .sda_in(sda), .sda_out(), .sda_oe_n(sda_oe_n_m), .addr_pin_bit_zero(1'b0),
        .addr_pin_bit_one(1'b1), .addr_pin_bit_two(1'b1), .chan0_irq_in_n(irq_n[0]), .chan1_irq_in_n(irq_n[1]),
        .chan2_irq_in_n(irq_n[2]), .chan3_irq_in_n(irq_n[3]), .irq_out(), .irq_oe_n(),
        .chan_connected(conn_m), .chan_data_oe_n(), .chan_clock_oe_n(), .channel_select(sel_m));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d0, input logic [7:0] d1, input logic exp_ack,
        input logic [3:0] old, input logic [3:0] nsel);
        logic ack;
        u_i2csw_master.start_c();
        chk({4'h0, data_oe_n}, {4'h0, ~old});
        u_i2csw_master.send_byte({a, 1'b0}, ack);
        chk({7'h00, ack}, {7'h00, exp_ack});
        if (ack === 1'b1) begin
            u_i2csw_master.send_byte(d0, ack);
            chk({7'h00, ack}, 8'h01);
            u_i2csw_master.send_byte(d1, ack);
        end
        chk({4'h0, sel}, {4'h0, old});
        u_i2csw_master.stop_c();
        chk({4'h0, sel}, {4'h0, nsel});
        chk({4'h0, conn}, {4'h0, nsel});
        chk({data_oe_n, clock_oe_n}, 8'hFF);
    endtask
    task automatic rd(input logic [7:0] e0, input logic [7:0] e1);
        logic ack;
        logic [7:0] d;
        u_i2csw_master.start_c();
        u_i2csw_master.send_byte({ADDR_SELF, 1'b1}, ack);
        chk({7'h00, ack}, 8'h01);
        u_i2csw_master.recv_byte(1'b0, d);
        chk(d, e0);
        u_i2csw_master.recv_byte(1'b1, d);
        chk(d, e1);
        u_i2csw_master.stop_c();
    endtask
    task automatic t_write;
        chk({sel, conn}, 8'h00);
        wr(ADDR_SELF, 8'hF3, 8'hA5, 1'b1, 4'h0, 4'h5);
        $display("test write done");
    endtask
    task automatic t_addr;
        pin0 <= 1'b1;
        pin1 <= 1'b0;
        repeat (10) @(posedge clk_sys);
        wr(ADDR_SELF, 8'h0F, 8'h0F, 1'b0, 4'h5, 4'h5);
        wr({ADDR_FIX5, 2'b01}, 8'h00, 8'h0C, 1'b1, 4'h5, 4'hC);
        pin0 <= 1'b0;
        pin1 <= 1'b1;
        repeat (10) @(posedge clk_sys);
        $display("test address done");
    endtask
    task automatic t_irq;
        irq_n <= 4'h5;
        repeat (42) @(posedge clk_sys);
        chk({7'h00, irq_oe_n}, 8'h00);
        rd(8'hAC, 8'hAC);
        wr(ADDR_SELF, 8'h08, 8'h08, 1'b1, 4'hC, 4'h8);
        irq_n <= 4'hF;
        repeat (22) @(posedge clk_sys);
        chk({7'h00, irq_oe_n}, 8'h01);
        rd(8'h08, 8'h08);
        $display("test interrupt done");
    endtask
    task automatic t_glitch;
        ok = 1'b1;
        irq_n <= 4'hE;
        repeat (5) @(posedge clk_sys);
        irq_n <= 4'hF;
        repeat (40) begin
            @(negedge clk_sys);
            ok = ok & irq_oe_n;
        end
        @(posedge clk_sys);
        chk({7'h00, ok}, 8'h01);
        irq_n <= 4'h7;
        repeat (42) @(posedge clk_sys);
        irq_n <= 4'hF;
        repeat (3) @(posedge clk_sys);
        irq_n <= 4'h7;
        ok = 1'b1;
        repeat (30) begin
            @(negedge clk_sys);
            ok = ok & ~irq_oe_n;
        end
        @(posedge clk_sys);
        chk({7'h00, ok}, 8'h01);
        irq_n <= 4'hF;
        repeat (22) @(posedge clk_sys);
        $display("test glitch done");
    endtask
    task automatic t_reset;
        wr(ADDR_SELF, 8'h00, 8'h0F, 1'b1, 4'h8, 4'hF);
        resetn <= 1'b0;
        @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (10) @(posedge clk_sys);
        chk({sel, conn}, 8'h00);
        rd(8'h00, 8'h00);
        $display("test reset done");
    endtask
    task automatic wm(input logic [7:0] d, input logic [7:0] exp);
        logic ack;
        u_i2csw_master.start_c();
        u_i2csw_master.send_byte({ADDR_MUX, 1'b0}, ack);
        chk({7'h00, ack}, 8'h01);
        u_i2csw_master.send_byte(d, ack);
        u_i2csw_master.stop_c();
        chk({sel_m, conn_m}, exp);
        chk({sel, conn}, 8'h00);
    endtask
    task automatic t_mux;
        wm(8'hFE, 8'h64);
        wm(8'h03, 8'h30);
        $display("test mux done");
    endtask
    initial begin
        // a real falling edge at time zero, so the link sampler, which has no free clock, is cleared too
        resetn <= 1'b0;
        repeat (10) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (10) @(posedge clk_sys);
        t_write();
        t_addr();
        t_irq();
        t_glitch();
        t_reset();
        t_mux();
        give_verdict();
    end
    initial begin
        repeat (30000) @(posedge clk_sys);
        fail_count++;
        give_verdict();
    end
endmodule
`default_nettype wire

// ==== core/i2csw_pkg.sv ====
// constants, types and timing counts for the four-channel i2c bus switch
// assumes the system clock runs at 10 MHz and the i2c clock is also routed to a link clock port
package i2csw_pkg;

    // device variants
    localparam logic [1:0] VAR_SWITCH2 = 2'h0; // switch, two address pins, interrupt inputs
    localparam logic [1:0] VAR_SWITCH3 = 2'h1; // switch, three address pins, no interrupt inputs
    localparam logic [1:0] VAR_MUX = 2'h2;     // 1:4 multiplexer, three address pins, interrupt inputs

    // slave address fixed parts
    localparam logic [4:0] ADDR_FIX5 = 5'h1C;
    localparam logic [3:0] ADDR_FIX4 = 4'hE;

    // register layout
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int SEL_W = 4;
    localparam int IRQ_LSB = 4;
    localparam int MUX_EN_BIT = 2;
    localparam int NCHAN = 4;

    // synchronised line positions
    localparam int LN_SDA = 0;
    localparam int LN_SCL = 1;
    localparam int LN_IRQ0 = 2;
    localparam int LN_APIN0 = 6;
    localparam int NLINE = 9;
    localparam int NFILT = 6;

    // timing
    localparam int CLK_MHZ = 10;
    localparam int SPIKE_NS = 50;
    localparam int IRQ_LOW_REJ_NS = 1000;
    localparam int IRQ_HIGH_REJ_NS = 500;
    localparam int SPIKE_CYC = (SPIKE_NS * CLK_MHZ / 1000 < 1) ? 1 : SPIKE_NS * CLK_MHZ / 1000;
    localparam int IRQ_LOW_CYC = (IRQ_LOW_REJ_NS * CLK_MHZ + 999) / 1000;
    localparam int IRQ_HIGH_CYC = (IRQ_HIGH_REJ_NS * CLK_MHZ + 999) / 1000;
    localparam int FCNT_W = 4;
    localparam int BITS_PER_BYTE = 8;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK,
        ST_WRITE,
        ST_READ,
        ST_RACK
    } i2csw_state_t;

endpackage

// ==== core/i2csw_top.sv ====
// i2c slave control logic of a four-channel bus switch or 1:4 multiplexer
// assumes scl and scl_link_clk carry the same upstream clock wire; pins are open drain, oe low drives
`timescale 1ns/100ps
`default_nettype none

// link side: samples data on each rising edge of the upstream clock
module i2csw_link (
    input wire logic scl_link_clk,
    input wire logic resetn,
    input wire logic sda_in,
    output logic bit_value,
    output logic bit_toggle
);
    import i2csw_pkg::*;

    typedef struct packed {
        logic bit_value;
        logic bit_toggle;
    } i2csw_link_t;

    i2csw_link_t r_q;
    i2csw_link_t r_d;

    always_comb begin
        r_d = r_q;
        r_d.bit_value = sda_in;
        r_d.bit_toggle = ~r_q.bit_toggle;
    end

    // the link clock stops between frames; nothing here needs an edge after the last bit
    always_ff @(posedge scl_link_clk or negedge resetn) begin
        if (!resetn) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign bit_value = r_q.bit_value;
    assign bit_toggle = r_q.bit_toggle;
endmodule

module i2csw_top #(
    parameter logic [1:0] VARIANT = VAR_SWITCH2
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic scl_link_clk,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic addr_pin_bit_zero,
    input wire logic addr_pin_bit_one,
    input wire logic addr_pin_bit_two,
    input wire logic chan0_irq_in_n,
    input wire logic chan1_irq_in_n,
    input wire logic chan2_irq_in_n,
    input wire logic chan3_irq_in_n,
    output logic irq_out,
    output logic irq_oe_n,
    output logic [i2csw_pkg::NCHAN-1:0] chan_connected,
    output logic [i2csw_pkg::NCHAN-1:0] chan_data_oe_n,
    output logic [i2csw_pkg::NCHAN-1:0] chan_clock_oe_n,
    output logic [i2csw_pkg::SEL_W-1:0] channel_select
);
    import i2csw_pkg::*;

    localparam logic HAS_IRQ = (VARIANT != VAR_SWITCH3);
    localparam logic IS_MUX = (VARIANT == VAR_MUX);
    localparam logic [SEL_W-1:0] SEL_MASK = IS_MUX ? 4'h7 : 4'hF;

    typedef struct packed {
        logic [2:0][NLINE-1:0] sy;
        logic [NLINE-1:0] acc;
        logic [2:0] tg;
        logic tg_acc;
        logic [NFILT-1:0] flt;
        logic [NFILT-1:0][FCNT_W-1:0] fcnt;
        i2csw_state_t st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] rd;
        logic ack_on;
        logic rw;
        logic [SEL_W-1:0] pend;
        logic pend_v;
        logic [SEL_W-1:0] sel;
        logic [NCHAN-1:0] irq_cap;
        logic sda_oe_n;
        logic irq_oe_n;
        logic [NCHAN-1:0] conn;
        logic [NCHAN-1:0] cd_oe_n;
        logic [NCHAN-1:0] cc_oe_n;
    } i2csw_state_s_t;

    i2csw_state_s_t r_q;
    i2csw_state_s_t r_d;
    logic link_bit;
    logic link_toggle;
    logic [NLINE-1:0] raw;

    i2csw_link u_link (
        .scl_link_clk(scl_link_clk),
        .resetn(resetn),
        .sda_in(sda_in),
        .bit_value(link_bit),
        .bit_toggle(link_toggle)
    );

    assign raw = {addr_pin_bit_two, addr_pin_bit_one, addr_pin_bit_zero,
                  chan3_irq_in_n, chan2_irq_in_n, chan1_irq_in_n, chan0_irq_in_n, scl, sda_in};

    always_comb begin
        logic [NLINE-1:0] acc_n;
        logic [FCNT_W-1:0] thr;
        logic bit_evt;
        logic sda_f;
        logic scl_f;
        logic scl_fall;
        logic start_evt;
        logic stop_evt;
        logic [6:0] my_addr;
        logic [NCHAN-1:0] irq_live;
        logic [SEL_W-1:0] sel_eff;
        logic [NCHAN-1:0] conn_n;
        acc_n = r_q.acc;
        thr = '0;
        bit_evt = 1'b0;
        sda_f = 1'b0;
        scl_f = 1'b0;
        scl_fall = 1'b0;
        start_evt = 1'b0;
        stop_evt = 1'b0;
        my_addr = '0;
        irq_live = '0;
        sel_eff = '0;
        conn_n = '0;
        r_d = r_q;

        // three-stage sampling; a change counts once stages two and three agree
        r_d.sy[0] = raw;
        r_d.sy[1] = r_q.sy[0];
        r_d.sy[2] = r_q.sy[1];
        for (int i = 0; i < NLINE; i++) begin
            if (r_q.sy[1][i] == r_q.sy[2][i]) begin
                acc_n[i] = r_q.sy[2][i];
            end
        end
        r_d.acc = acc_n;

        r_d.tg[0] = link_toggle;
        r_d.tg[1] = r_q.tg[0];
        r_d.tg[2] = r_q.tg[1];
        bit_evt = (r_q.tg[1] == r_q.tg[2]) && (r_q.tg[2] != r_q.tg_acc);
        if (bit_evt) begin
            r_d.tg_acc = r_q.tg[2];
        end

        // pulse filters: a line changes only after its new level has lasted thr cycles
        for (int i = 0; i < NFILT; i++) begin
            if (i < LN_IRQ0) begin
                thr = FCNT_W'(SPIKE_CYC);
            end else if (r_q.flt[i]) begin
                thr = FCNT_W'(IRQ_LOW_CYC);
            end else begin
                thr = FCNT_W'(IRQ_HIGH_CYC);
            end
            if (acc_n[i] != r_q.flt[i]) begin
                if (r_q.fcnt[i] + FCNT_W'(1) >= thr) begin
                    r_d.flt[i] = acc_n[i];
                    r_d.fcnt[i] = '0;
                end else begin
                    r_d.fcnt[i] = r_q.fcnt[i] + FCNT_W'(1);
                end
            end else begin
                r_d.fcnt[i] = '0;
            end
        end

        sda_f = r_q.flt[LN_SDA];
        scl_f = r_q.flt[LN_SCL];
        scl_fall = r_q.flt[LN_SCL] && !r_d.flt[LN_SCL];
        start_evt = scl_f && r_d.flt[LN_SCL] && sda_f && !r_d.flt[LN_SDA];
        stop_evt = scl_f && r_d.flt[LN_SCL] && !sda_f && r_d.flt[LN_SDA];

        if (VARIANT == VAR_SWITCH2) begin
            my_addr = {ADDR_FIX5, r_q.acc[LN_APIN0+1], r_q.acc[LN_APIN0]};
        end else begin
            my_addr = {ADDR_FIX4, r_q.acc[LN_APIN0+2:LN_APIN0]};
        end

        // not latched, honoured whether connected or not
        irq_live = HAS_IRQ ? ~r_q.flt[LN_IRQ0+NCHAN-1:LN_IRQ0] : '0;
        r_d.irq_oe_n = ~(|irq_live);

        unique case (r_q.st)
            ST_IDLE: begin
            end
            ST_ADDR: begin
                if (bit_evt) begin
                    r_d.sh = {r_q.sh[6:0], link_bit};
                    r_d.cnt = r_q.cnt + 4'h1;
                    if (r_q.cnt == 4'(BITS_PER_BYTE - 1)) begin
                        if (r_q.sh[6:0] == my_addr) begin
                            r_d.rw = link_bit;
                            r_d.ack_on = 1'b0;
                            r_d.st = ST_ACK;
                        end else begin
                            r_d.st = ST_IDLE;
                        end
                    end
                end
            end
            ST_ACK: begin
                if (scl_fall) begin
                    if (!r_q.ack_on) begin
                        r_d.ack_on = 1'b1;
                        r_d.sda_oe_n = 1'b0;
                    end else begin
                        r_d.ack_on = 1'b0;
                        r_d.cnt = '0;
                        if (r_q.rw) begin
                            r_d.irq_cap = irq_live;
                            r_d.rd = {irq_live, r_q.sel & SEL_MASK};
                            r_d.sda_oe_n = irq_live[NCHAN-1];
                            r_d.st = ST_READ;
                        end else begin
                            r_d.sda_oe_n = 1'b1;
                            r_d.st = ST_WRITE;
                        end
                    end
                end
            end
            ST_WRITE: begin
                if (bit_evt) begin
                    r_d.sh = {r_q.sh[6:0], link_bit};
                    r_d.cnt = r_q.cnt + 4'h1;
                    if (r_q.cnt == 4'(BITS_PER_BYTE - 1)) begin
                        r_d.pend = {r_q.sh[2:0], link_bit} & SEL_MASK;
                        r_d.pend_v = 1'b1;
                        r_d.ack_on = 1'b0;
                        r_d.st = ST_ACK;
                    end
                end
            end
            ST_READ: begin
                if (bit_evt) begin
                    r_d.cnt = r_q.cnt + 4'h1;
                end
                if (scl_fall) begin
                    if (r_q.cnt >= 4'(BITS_PER_BYTE)) begin
                        r_d.sda_oe_n = 1'b1;
                        r_d.st = ST_RACK;
                    end else begin
                        r_d.sda_oe_n = r_q.rd[3'(BITS_PER_BYTE - 1) - r_q.cnt[2:0]];
                    end
                end
            end
            ST_RACK: begin
                if (bit_evt) begin
                    if (link_bit) begin
                        r_d.st = ST_IDLE;
                    end else begin
                        r_d.ack_on = 1'b1; // next fall loads a fresh byte
                        r_d.st = ST_ACK;
                    end
                end
            end
        endcase

        if (start_evt) begin
            r_d.st = ST_ADDR;
            r_d.cnt = '0;
            r_d.sda_oe_n = 1'b1;
        end
        if (stop_evt) begin
            r_d.st = ST_IDLE;
            r_d.sda_oe_n = 1'b1;
            r_d.pend_v = 1'b0;
            if (r_q.pend_v) begin
                r_d.sel = r_q.pend;
            end
        end

        // channel decode from the applied selection
        sel_eff = r_q.sel & SEL_MASK;
        if (IS_MUX) begin
            conn_n = sel_eff[MUX_EN_BIT] ? (NCHAN'(1) << sel_eff[1:0]) : '0;
        end else begin
            conn_n = sel_eff;
        end
        r_d.conn = conn_n;
        // bus is idle high right after stop, so a fresh channel sees both lines high
        for (int c = 0; c < NCHAN; c++) begin
            r_d.cd_oe_n[c] = !(conn_n[c] && r_q.conn[c] && !sda_f);
            r_d.cc_oe_n[c] = !(conn_n[c] && r_q.conn[c] && !scl_f);
        end
    end

    // one reset serves power-on and the reset pin
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            r_q <= '{sy: '1, acc: '1, tg: '0, tg_acc: 1'b0, flt: '1, fcnt: '0, st: ST_IDLE,
                     cnt: '0, sh: '0, rd: REG_RESET, ack_on: 1'b0, rw: 1'b0, pend: '0,
                     pend_v: 1'b0, sel: '0, irq_cap: '0, sda_oe_n: 1'b1, irq_oe_n: 1'b1,
                     conn: '0, cd_oe_n: '1, cc_oe_n: '1};
        end else begin
            r_q <= r_d;
        end
    end

    assign sda_out = 1'b0;
    assign irq_out = 1'b0;
    assign sda_oe_n = r_q.sda_oe_n;
    assign irq_oe_n = r_q.irq_oe_n;
    assign chan_connected = r_q.conn;
    assign chan_data_oe_n = r_q.cd_oe_n;
    assign chan_clock_oe_n = r_q.cc_oe_n;
    assign channel_select = r_q.sel;
endmodule

`default_nettype wire
